/* hdl/pts_pkg.sv */
// Shared constants and helpers for the process data scheduler ends.
package pts_pkg;
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          MS_NS         = 1000000;
    localparam int          MS_CYC_DEF    = MS_NS / CLK_PERIOD_NS;
    localparam logic [15:0] SYNC_MS_DEF   = 16'h0032;
    localparam int          DW            = 32;
    localparam int          FIFO_DEPTH    = 8;
    // Transmission type codes.
    localparam logic [7:0]  TYPE_ACYC     = 8'h00;
    localparam logic [7:0]  TYPE_N_MIN    = 8'h01;
    localparam logic [7:0]  TYPE_N_MAX    = 8'hF0;
    localparam logic [7:0]  TYPE_ASYNC_A  = 8'hFE;
    localparam logic [7:0]  TYPE_ASYNC_B  = 8'hFF;
    // Controller register byte offsets.
    localparam logic [7:0]  A_CTRL        = 8'h00;
    localparam logic [7:0]  A_PERIOD      = 8'h04;
    localparam logic [7:0]  A_RXTYPE      = 8'h08;
    localparam logic [7:0]  A_RXDATA      = 8'h0C;
    localparam logic [7:0]  A_TXDATA      = 8'h10;
    localparam logic [7:0]  A_STATUS      = 8'h14;
    localparam int          CTRL_SYNC_EN  = 0;
    localparam int          ST_TX_NEW     = 0;
    localparam int          ST_RX_PEND    = 1;
    localparam logic        SYNC_EN_RST   = 1'b1;
    localparam logic [7:0]  RXTYPE_RST    = 8'hFF;

    function automatic logic is_async(input logic [7:0] t);
        return (t == TYPE_ASYNC_A) || (t == TYPE_ASYNC_B);
    endfunction

    function automatic logic is_cyclic(input logic [7:0] t);
        return (t >= TYPE_N_MIN) && (t <= TYPE_N_MAX);
    endfunction
endpackage

/* hdl/pts_if.sv */
// Link between the network master end and the slave node end.
interface pts_if;
    logic        sync;     // SYNC message, one-cycle pulse
    logic        rx_valid; // Receive object frame, one-cycle pulse
    logic [31:0] rx_data;  // Receive object payload
    logic        tx_valid; // Transmit object frame, one-cycle pulse
    logic [31:0] tx_data;  // Transmit object payload

    modport master (output sync, output rx_valid, output rx_data,
                    input tx_valid, input tx_data);
    modport node   (input sync, input rx_valid, input rx_data,
                    output tx_valid, output tx_data);
endinterface

/* hdl/pts_node.sv */
// Slave node end: applies receive objects and schedules transmit objects.
module pts_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 8
) (
    input  wire logic         hclk,      // Clock
    input  wire logic         hresetn,   // Async reset, active low
    input  wire logic         in_valid,  // Write request
    output logic              in_ready,  // Space available
    input  wire logic [W-1:0] in_data,   // Write data
    output logic              out_valid, // Data available
    input  wire logic         out_ready, // Read request
    output logic [W-1:0]      out_data   // Head word
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("FIFO depth must be a power of two of at least 2");
    end
    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wp_q, wp_d, rp_q, rp_d;
    logic         push, pop;

    always_comb begin
        in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
        out_valid = wp_q != rp_q;
        out_data  = mem[rp_q[AW-1:0]];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wp_d      = push ? wp_q + 1'b1 : wp_q;
        rp_d      = pop ? rp_q + 1'b1 : rp_q;
    end

    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wp_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end
endmodule

module pts_node import pts_pkg::*; #(
    parameter int MS_CYCLES = MS_CYC_DEF
) (
    input  wire logic        hclk,         // Clock, 100 MHz
    input  wire logic        hresetn,      // Async reset, active low
    pts_if.node              lnk,          // Network link
    input  wire logic [7:0]  rx_type,      // Receive object transmission type
    input  wire logic [7:0]  tx_type,      // Transmit object transmission type
    input  wire logic [15:0] evt_ms,       // Event timer in ms
    input  wire logic [15:0] inh_ms,       // Inhibit timer in ms
    output logic [31:0]      app_rx_data,  // Applied receive value
    output logic             app_rx_apply, // Pulse when a value takes effect
    input  wire logic        app_tx_valid, // New mapped value offered
    output logic             app_tx_ready, // Mapped value accepted
    input  wire logic [31:0] app_tx_data   // Mapped value
);
    localparam int MW = $clog2(MS_CYCLES);
    if (MS_CYCLES < 2) begin : g_chk
        $error("MS_CYCLES must be at least 2");
    end

    logic [MW-1:0] ms_q, ms_d, ims_q, ims_d;
    logic          tick, itick;
    logic [31:0]   pend_q, pend_d, app_q, app_d, cur_q, cur_d, txd_q, txd_d;
    logic          pendv_q, pendv_d, apply_q, apply_d, chg_q, chg_d, txv_q, txv_d;
    logic [7:0]    nsync_q, nsync_d;
    logic [15:0]   evt_q, evt_d, inh_q, inh_d;
    logic          f_valid, f_pop, send, inh_done;
    logic [31:0]   f_data;

    // Staging the mapped values lets the application run ahead while the
    // scheduler is held back by SYNC, the inhibit timer or an unsent change.
    pts_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (app_tx_valid),
        .in_ready  (app_tx_ready),
        .in_data   (app_tx_data),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_data)
    );

    always_comb begin
        tick     = ms_q == MW'(MS_CYCLES - 1);
        ms_d     = tick ? '0 : ms_q + 1'b1;
        inh_done = inh_q == 16'h0000;
        itick    = ims_q == MW'(MS_CYCLES - 1);
        // Receive side: sync types wait for SYNC, async types apply at once.
        pend_d   = pend_q;
        pendv_d  = pendv_q;
        app_d    = app_q;
        apply_d  = 1'b0;
        if (lnk.sync && pendv_q) begin // R12
            app_d   = pend_q; // R4 R6
            apply_d = 1'b1;
            pendv_d = 1'b0;
        end
        if (lnk.rx_valid) begin // R1
            if (is_async(rx_type)) begin
                app_d   = lnk.rx_data; // R8
                apply_d = 1'b1;
            end else begin
                pend_d  = lnk.rx_data;
                pendv_d = 1'b1;
            end
        end
        // Transmit side scheduling.
        send    = 1'b0;
        nsync_d = nsync_q;
        if (tx_type == TYPE_ACYC) begin
            send = lnk.sync && chg_q; // R5
        end else if (is_cyclic(tx_type) && lnk.sync) begin
            if (nsync_q + 8'h01 >= tx_type) begin
                send    = 1'b1; // R7
                nsync_d = 8'h00; // R13
            end else begin
                nsync_d = nsync_q + 8'h01;
            end
        end else if (is_async(tx_type)) begin
            if (evt_ms == 16'h0000) begin
                send = chg_q && inh_done; // R10
            end else begin
                send = inh_done && (evt_q + 16'h0001 >= evt_ms) && tick; // R9
            end
        end
        evt_d = evt_q;
        if (send) begin
            evt_d = 16'h0000;
        end else if (tick && evt_q != 16'hFFFF) begin
            evt_d = evt_q + 16'h0001;
        end
        // The inhibit timer keeps its own millisecond phase, restarted by each
        // send, so a tick already under way never cuts the silence short.
        inh_d = inh_q;
        ims_d = (send || itick) ? '0 : ims_q + 1'b1;
        if (send) begin
            inh_d = inh_ms; // R9 R13
        end else if (itick && !inh_done) begin
            inh_d = inh_q - 16'h0001;
        end
        txv_d = send;
        txd_d = send ? cur_q : txd_q;
        // Outside cyclic types, an unsent change holds the next word back so none is skipped.
        f_pop = f_valid && (!chg_q || send || is_cyclic(tx_type));
        cur_d = f_pop ? f_data : cur_q;
        chg_d = chg_q && !send;
        if (f_pop && f_data != cur_q) begin
            chg_d = 1'b1; // R3
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ms_q    <= '0;
            ims_q   <= '0;
            pend_q  <= '0;
            pendv_q <= 1'b0;
            app_q   <= '0;
            apply_q <= 1'b0;
            cur_q   <= '0;
            chg_q   <= 1'b0;
            txv_q   <= 1'b0;
            txd_q   <= '0;
            nsync_q <= 8'h00;
            evt_q   <= 16'h0000;
            inh_q   <= 16'h0000;
        end else begin
            ms_q    <= ms_d;
            ims_q   <= ims_d;
            pend_q  <= pend_d;
            pendv_q <= pendv_d;
            app_q   <= app_d;
            apply_q <= apply_d;
            cur_q   <= cur_d;
            chg_q   <= chg_d;
            txv_q   <= txv_d;
            txd_q   <= txd_d;
            nsync_q <= nsync_d;
            evt_q   <= evt_d;
            inh_q   <= inh_d;
        end
    end

    assign lnk.tx_valid = txv_q;
    assign lnk.tx_data  = txd_q;
    assign app_rx_data  = app_q;
    assign app_rx_apply = apply_q;
endmodule

/* hdl/pts_master.sv */
// Network master end: SYNC generator, receive object sender, AHB-Lite registers.
// Rules, split between this block and pts_node
// R1: Receive objects go master to slave, transmit back.
// R2: Master emits SYNC periodically, default 50 ms.
// R3: Asynchronous objects are sent on value change; transmit ones only while the event timer is zero.
// R4: Receive type 0: send on change, apply at SYNC.
// R5: Transmit type 0: send at SYNC if changed.
// R6: Receive type N: send every N SYNCs, apply next.
// R7: Transmit type N: slave sends every N SYNCs.
// R8: Receive 254/255: send on change, apply at once.
// R9: Transmit 254/255: event period, then inhibit silence.
// R10: Both timers zero: send immediately on change.
// R11: Fast monitored values should use synchronous types.
// R12: Synchronous types let axes update together.
// R13: Per object SYNC counter and inhibit restart on send.
module pts_master import pts_pkg::*; #(
    parameter int MS_CYCLES = MS_CYC_DEF
) (
    input  wire logic        hclk,      // Clock, 100 MHz
    input  wire logic        hresetn,   // Async reset, active low
    input  wire logic        hsel,      // AHB slave select
    input  wire logic [31:0] haddr,     // AHB address
    input  wire logic [1:0]  htrans,    // AHB transfer type
    input  wire logic        hwrite,    // AHB write
    input  wire logic [2:0]  hsize,     // AHB size, word only
    input  wire logic [31:0] hwdata,    // AHB write data
    input  wire logic        hready,    // AHB bus ready
    output logic             hreadyout, // AHB slave ready
    output logic             hresp,     // AHB response, always OKAY
    output logic [31:0]      hrdata,    // AHB read data
    pts_if.master            lnk        // Network link
);
    localparam int MW = $clog2(MS_CYCLES);
    if (MS_CYCLES < 2) begin : g_chk
        $error("MS_CYCLES must be at least 2");
    end

    logic [MW-1:0] ms_q, ms_d;
    logic          tick;
    logic          en_q, en_d, sync_q, sync_d;
    logic [15:0]   per_q, per_d, pcnt_q, pcnt_d;
    logic [7:0]    rxt_q, rxt_d, nsync_q, nsync_d;
    logic [31:0]   rxv_q, rxv_d, rxd_q, rxd_d, txd_q, txd_d, rd_q, rd_d;
    logic          chg_q, chg_d, rxs_q, rxs_d, txn_q, txn_d;
    logic          wr_q, wr_d, send, sel;
    logic [7:0]    ad_q, ad_d;

    function automatic logic [31:0] reg_read(input logic [7:0] a);
        unique case (a)
            A_CTRL:   reg_read = {31'h0, en_q};
            A_PERIOD: reg_read = {16'h0000, per_q};
            A_RXTYPE: reg_read = {24'h000000, rxt_q};
            A_RXDATA: reg_read = rxv_q;
            A_TXDATA: reg_read = txd_q;
            A_STATUS: reg_read = {30'h0, chg_q, txn_q};
            default:  reg_read = 32'h00000000;
        endcase
    endfunction

    always_comb begin
        sel  = hsel && hready && htrans[1];
        wr_d = sel && hwrite;
        ad_d = sel ? haddr[7:0] : ad_q;
        rd_d = (sel && !hwrite) ? reg_read(haddr[7:0]) : rd_q;
        // SYNC generator on a millisecond tick.
        tick   = ms_q == MW'(MS_CYCLES - 1);
        ms_d   = tick ? '0 : ms_q + 1'b1;
        sync_d = 1'b0;
        pcnt_d = pcnt_q;
        if (en_q && tick) begin
            if (pcnt_q + 16'h0001 >= per_q) begin
                sync_d = 1'b1; // R2
                pcnt_d = 16'h0000;
            end else begin
                pcnt_d = pcnt_q + 16'h0001;
            end
        end
        // Receive object scheduling.
        send    = 1'b0;
        nsync_d = nsync_q;
        if (is_cyclic(rxt_q)) begin
            if (sync_q) begin
                if (nsync_q + 8'h01 >= rxt_q) begin
                    send    = 1'b1; // R6
                    nsync_d = 8'h00; // R13
                end else begin
                    nsync_d = nsync_q + 8'h01;
                end
            end
        end else if (rxt_q == TYPE_ACYC || is_async(rxt_q)) begin
            send = chg_q; // R3 R4 R8
        end
        rxs_d = send; // R1
        rxd_d = send ? rxv_q : rxd_q;
        // Register writes; a fresh change or arrival beats its clear.
        en_d  = en_q;
        per_d = per_q;
        rxt_d = rxt_q;
        rxv_d = rxv_q;
        chg_d = chg_q && !send;
        txn_d = txn_q;
        if (wr_q) begin
            unique case (ad_q)
                A_CTRL:   en_d = hwdata[CTRL_SYNC_EN];
                A_PERIOD: per_d = hwdata[15:0];
                A_RXTYPE: rxt_d = hwdata[7:0];
                A_RXDATA: begin
                    rxv_d = hwdata;
                    if (hwdata != rxv_q) begin
                        chg_d = 1'b1;
                    end
                end
                A_STATUS: begin
                    if (hwdata[ST_TX_NEW]) begin
                        txn_d = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        txd_d = txd_q;
        if (lnk.tx_valid) begin
            txd_d = lnk.tx_data; // R5 R7 R10
            txn_d = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ms_q      <= '0;
            en_q      <= SYNC_EN_RST;
            sync_q    <= 1'b0;
            per_q     <= SYNC_MS_DEF;
            pcnt_q    <= 16'h0000;
            rxt_q     <= RXTYPE_RST;
            nsync_q   <= 8'h00;
            rxv_q     <= '0;
            rxd_q     <= '0;
            txd_q     <= '0;
            rd_q      <= '0;
            chg_q     <= 1'b0;
            rxs_q     <= 1'b0;
            txn_q     <= 1'b0;
            wr_q      <= 1'b0;
            ad_q      <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            ms_q      <= ms_d;
            en_q      <= en_d;
            sync_q    <= sync_d;
            per_q     <= per_d;
            pcnt_q    <= pcnt_d;
            rxt_q     <= rxt_d;
            nsync_q   <= nsync_d;
            rxv_q     <= rxv_d;
            rxd_q     <= rxd_d;
            txd_q     <= txd_d;
            rd_q      <= rd_d;
            chg_q     <= chg_d;
            rxs_q     <= rxs_d;
            txn_q     <= txn_d;
            wr_q      <= wr_d;
            ad_q      <= ad_d;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata       = rd_q;
    assign lnk.sync     = sync_q;
    assign lnk.rx_valid = rxs_q;
    assign lnk.rx_data  = rxd_q;
endmodule

/* bench/pts_link_chk.sv */
// Protocol checker for the link between the master and node ends.
module pts_link_chk (
    input  wire logic        hclk,     // Clock
    input  wire logic        hresetn,  // Async reset, active low
    input  wire logic        sync,     // SYNC pulse
    input  wire logic        rx_valid, // Receive frame
    input  wire logic [31:0] rx_data,  // Receive payload
    input  wire logic        tx_valid, // Transmit frame
    input  wire logic [31:0] tx_data   // Transmit payload
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // The bench never stops SYNC for long, so a bounded gap catches a dead generator.
    logic [10:0] gap_q;
    logic [10:0] gap_d;
    always_comb gap_d = sync ? 11'h000 : gap_q + 11'h001;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) gap_q <= 11'h000;
        else gap_q <= gap_d;
    end
    property p_sync_gap; gap_q < 11'h3E8; endproperty
    a_sync_gap: assert property (p_sync_gap) else $error("SYNC gap too long");
    property p_sync_space; sync |=> (!sync) [*8]; endproperty
    a_sync_space: assert property (p_sync_space) else $error("SYNC too close");
    property p_rx_pulse; rx_valid |=> !rx_valid; endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("receive frame too long");
    property p_tx_pulse; tx_valid |=> !tx_valid; endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("transmit frame too long");
    property p_rx_hold; !rx_valid |-> $stable(rx_data); endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("receive data moved");
    property p_tx_hold; !tx_valid |-> $stable(tx_data); endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("transmit data moved");
    property p_tx_solo; tx_valid |-> !$past(tx_valid, 1); endproperty
    a_tx_solo: assert property (p_tx_solo) else $error("transmit frames merged");
endmodule

/* bench/tb.sv */
// Self-checking bench for the master and node ends with a queue of expected transmit words.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pts_pkg::*;
    localparam int MSC = 10;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [7:0]  rx_type = 8'hFF;
    logic [7:0]  tx_type = 8'h00;
    logic [15:0] evt_ms = 16'h0;
    logic [15:0] inh_ms = 16'h0;
    logic [31:0] app_rx_data;
    logic        app_rx_apply;
    logic        app_tx_valid = 1'b0;
    logic        app_tx_ready;
    logic [31:0] app_tx_data = 32'h0;
    logic [31:0] r;
    logic [31:0] v;
    logic [31:0] txq[$];
    logic [7:0]  ra[7] = '{A_CTRL, A_PERIOD, A_RXTYPE, A_RXDATA, A_TXDATA, A_STATUS, 8'h20};
    logic [31:0] rv[7] = '{32'(SYNC_EN_RST), 32'(SYNC_MS_DEF), 32'(RXTYPE_RST), 32'h0, 32'h0,
                           32'h0, 32'h0};
    int          fail_count = 0;
    int          n_tests = 0;
    int          n_sync = 0;
    int          n_rx = 0;
    int          n_tx = 0;
    int          cyc = 0;
    int          t_tx = 0;
    int          t_gap = 0;
    int          t_sync = 0;
    int          n_app = 0;
    int          s;
    int          acc;

    pts_if pts_if_i ();
    pts_master #(.MS_CYCLES(MSC)) pts_master_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .lnk(pts_if_i));
    pts_node #(.MS_CYCLES(MSC)) pts_node_i (.hclk(hclk), .hresetn(hresetn), .lnk(pts_if_i),
        .rx_type(rx_type), .tx_type(tx_type), .evt_ms(evt_ms), .inh_ms(inh_ms),
        .app_rx_data(app_rx_data), .app_rx_apply(app_rx_apply), .app_tx_valid(app_tx_valid),
        .app_tx_ready(app_tx_ready), .app_tx_data(app_tx_data));
    pts_link_chk pts_link_chk_i (.hclk(hclk), .hresetn(hresetn), .sync(pts_if_i.sync),
        .rx_valid(pts_if_i.rx_valid), .rx_data(pts_if_i.rx_data),
        .tx_valid(pts_if_i.tx_valid), .tx_data(pts_if_i.tx_data));

    always #5 hclk = ~hclk;

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Monitor samples mid-cycle so flop outputs have settled.
    always @(negedge hclk) begin
        cyc++;
        if (pts_if_i.sync === 1'b1) begin
            n_sync++;
            t_sync = cyc;
        end
        if (app_rx_apply === 1'b1) n_app++;
        if (pts_if_i.rx_valid === 1'b1) n_rx++;
        if (pts_if_i.tx_valid === 1'b1) begin
            n_tx++;
            t_gap = cyc - t_tx;
            t_tx = cyc;
            if (txq.size() > 0) chk(pts_if_i.tx_data, txq.pop_front(), "tx_frame");
        end
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end

    task automatic wev(ref int c, input int k);
        int b;
        b = c;
        while (c < b + k) @(negedge hclk);
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic push(input logic [31:0] d);
        @(posedge hclk);
        app_tx_valid <= 1'b1;
        app_tx_data <= d;
        @(negedge hclk);
        while (app_tx_ready !== 1'b1) @(negedge hclk);
        @(posedge hclk);
        app_tx_valid <= 1'b0;
    endtask

    initial begin
        void'($urandom(77));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            ahb(1'b0, ra[i], 32'h0, r);
            chk(r, rv[i], "reset_reg");
        end
        ahb(1'b1, A_PERIOD, 32'h1, r);
        ahb(1'b1, A_CTRL, 32'h0, r);
        s = n_sync;
        repeat (40) @(negedge hclk);
        chk(n_sync - s, 0, "sync_off");
        ahb(1'b1, A_CTRL, 32'h1, r);
        wev(n_sync, 2);
        v = $urandom;
        s = n_rx;
        ahb(1'b1, A_RXDATA, v, r);
        wev(n_rx, 1);
        repeat (2) @(negedge hclk);
        chk(app_rx_data, v, "rx_async");
        chk(n_app, 1, "rx_apply");
        ahb(1'b1, A_RXDATA, v, r);
        repeat (30) @(negedge hclk);
        chk(n_rx - s, 1, "rx_nochange");
        ahb(1'b1, A_RXTYPE, 32'h0, r);
        rx_type <= TYPE_ACYC;
        ahb(1'b1, A_RXDATA, ~v, r);
        wev(n_rx, 1);
        @(negedge hclk);
        chk(app_rx_data, v, "rx_held");
        wev(n_sync, 1);
        repeat (2) @(negedge hclk);
        chk(app_rx_data, ~v, "rx_at_sync");
        chk(n_app, 2, "rx_apply_sync");
        ahb(1'b1, A_RXTYPE, 32'h3, r);
        rx_type <= 8'h03;
        wev(n_rx, 1);
        s = n_rx;
        wev(n_sync, 6);
        repeat (3) @(negedge hclk);
        chk(n_rx - s, 2, "rx_every_3");
        v = $urandom;
        txq.push_back(v);
        push(v);
        wev(n_tx, 1);
        repeat (3) @(negedge hclk);
        chk(t_tx - t_sync, 1, "tx_after_sync");
        ahb(1'b0, A_TXDATA, 32'h0, r);
        chk(r, v, "txdata");
        ahb(1'b0, A_STATUS, 32'h0, r);
        chk(r[ST_TX_NEW], 1'b1, "tx_new");
        ahb(1'b1, A_STATUS, 32'h1, r);
        s = n_tx;
        wev(n_sync, 2);
        chk(n_tx - s, 0, "tx_nochange");
        ahb(1'b0, A_STATUS, 32'h0, r);
        chk(r[ST_TX_NEW], 1'b0, "tx_new_clr");
        // Fill while SYNC paces the drain, so the node side stalls the buffer.
        acc = 0;
        @(posedge hclk);
        app_tx_valid <= 1'b1;
        v = ($urandom & 32'hFFFFFF00) | 32'h10;
        app_tx_data <= v;
        for (int i = 0; i < 14; i++) begin
            @(negedge hclk);
            if (app_tx_ready !== 1'b1) break;
            @(posedge hclk);
            txq.push_back(v);
            acc++;
            v = ($urandom & 32'hFFFFFF00) | (i + 32'h20);
            app_tx_data <= v;
        end
        chk(app_tx_ready, 1'b0, "fifo_full");
        chk(acc >= FIFO_DEPTH, 1, "fifo_depth");
        @(posedge hclk);
        app_tx_valid <= 1'b0;
        while (txq.size() > 0) @(negedge hclk);
        chk(app_tx_ready, 1'b1, "fifo_drained");
        tx_type <= 8'h02;
        wev(n_tx, 1);
        s = n_tx;
        wev(n_sync, 4);
        repeat (3) @(negedge hclk);
        chk(n_tx - s, 2, "tx_every_2");
        tx_type <= TYPE_ASYNC_A;
        wev(n_sync, 1);
        v = $urandom;
        txq.push_back(v);
        s = cyc;
        push(v);
        wev(n_tx, 1);
        chk(t_tx - s <= 6, 1, "tx_immediate");
        tx_type <= TYPE_ASYNC_B;
        inh_ms <= 16'h3;
        repeat (2) @(posedge hclk);
        for (int i = 0; i < 2; i++) begin
            v = $urandom;
            txq.push_back(v);
            push(v);
        end
        wev(n_tx, 2);
        chk(t_gap >= 3 * MSC && t_gap <= 5 * MSC, 1, "tx_inhibit");
        evt_ms <= 16'h2;
        inh_ms <= 16'h0;
        wev(n_tx, 2);
        chk(t_gap, 2 * MSC, "tx_event");
        conclude();
    end
endmodule
